// file: design/txarb_top.sv
// Transmit arbitration between user packets and self-generated packets.
`timescale 1ns/1ps
`default_nettype none
module txarb_top
    import txarb_pkg::*;
#(
    parameter int INT_LEN = TXARB_INT_LEN
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // User transmit stream in.
    input wire logic user_valid,
    input wire logic user_last,
    input wire logic [txarb_pkg::TXARB_SB_W-1:0] user_sb,
    output logic user_ready,
    // Internal packet arbitration.
    output logic int_req,
    input wire logic int_gnt,
    // Packet output toward the link.
    output logic out_valid,
    output logic out_last,
    output logic out_own,
    output logic out_poison,
    output logic out_digest,
    output logic out_cut,
    input wire logic out_ready
);
    import txarb_pkg::*;

    txarb_state_t state_reg;
    logic [1:0] ctrl_reg;
    logic latch_reg;
    logic in_pkt_reg;
    logic poison_reg;
    logic digest_reg;
    logic cut_reg;
    logic viol_reg;
    logic [7:0] beat_reg;
    logic [15:0] cnt_reg;
    logic gen_pend_reg;
    logic user_beat;
    logic own_beat;
    logic apb_wr;
    logic apb_rd;
    logic [31:0] rd_next;

    // ------------------------------------------------------------------
    // APB access
    // ------------------------------------------------------------------
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;

    // Control register: generate strobe and buffer space available.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= TXARB_CTRL_RST;
        end else if (apb_wr && paddr == TXARB_CTRL_OFS) begin
            ctrl_reg <= pwdata[1:0];
        end else begin
            ctrl_reg[TXARB_CTRL_GEN_BIT] <= 1'b0; // Generate is a self-clearing strobe.
        end
    end

    // Read mux; unmapped addresses read zero and report an error.
    always_comb begin
        rd_next = 32'h0;
        case (paddr)
            TXARB_CTRL_OFS: rd_next[1:0] = ctrl_reg;
            TXARB_STAT_OFS: begin
                rd_next[TXARB_STAT_REQ_BIT] = int_req;
                rd_next[TXARB_STAT_LATCH_BIT] = latch_reg;
                rd_next[TXARB_STAT_PEND_BIT] = gen_pend_reg;
                rd_next[TXARB_STAT_INPKT_BIT] = in_pkt_reg;
                rd_next[TXARB_STAT_VIOL_BIT] = viol_reg;
            end
            TXARB_CNT_OFS: rd_next[15:0] = cnt_reg;
            default: rd_next = 32'h0;
        endcase
    end

    // Answer in the first access cycle: pready rises in setup, read data registered.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && paddr != TXARB_CTRL_OFS
                       && paddr != TXARB_STAT_OFS && paddr != TXARB_CNT_OFS;
            if (apb_rd) begin
                prdata <= rd_next;
            end
        end
    end

    // ------------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------------
    assign user_beat = user_valid && user_ready;
    assign own_beat = out_valid && out_own && out_ready;

    // Pending self-generated packet, set by software strobe; set wins over clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_pend_reg <= 1'b0;
        end else if (ctrl_reg[TXARB_CTRL_GEN_BIT]) begin
            gen_pend_reg <= 1'b1;
        end else if (state_reg == TXARB_REQ) begin
            gen_pend_reg <= 1'b0;
        end
    end

    // User packet tracking: open after a first beat, closed on the last beat.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_pkt_reg <= 1'b0;
        end else if (user_beat) begin
            in_pkt_reg <= !user_last;
        end
    end

    // Request state machine.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= TXARB_IDLE;
            int_req <= 1'b0;
            latch_reg <= 1'b0;
            beat_reg <= 8'h0;
        end else begin
            case (state_reg)
                TXARB_IDLE: begin
                    if (gen_pend_reg && !int_req) begin
                        int_req <= 1'b1;
                        state_reg <= TXARB_REQ;
                    end
                end
                TXARB_REQ: begin
                    if (int_gnt || latch_reg) begin
                        latch_reg <= 1'b1;
                        if (ctrl_reg[TXARB_CTRL_SPACE_BIT]) begin
                            state_reg <= TXARB_WAIT_BND;
                        end
                    end
                end
                TXARB_WAIT_BND: begin
                    if (!in_pkt_reg && !user_beat) begin
                        state_reg <= TXARB_SEND;
                        beat_reg <= 8'h0;
                    end
                end
                TXARB_SEND: begin
                    if (own_beat) begin
                        beat_reg <= beat_reg + 8'h1;
                        if (beat_reg == 8'(INT_LEN - 1)) begin
                            int_req <= 1'b0;
                            latch_reg <= 1'b0;
                            state_reg <= TXARB_IDLE;
                        end
                    end
                end
                default: state_reg <= TXARB_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Output stream
    // ------------------------------------------------------------------
    // User beats flow unless the own packet holds the boundary.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            user_ready <= 1'b0;
        end else begin
            user_ready <= out_ready && !(user_beat && user_last)
                && (state_reg == TXARB_IDLE || state_reg == TXARB_REQ
                    || (in_pkt_reg && state_reg == TXARB_WAIT_BND));
        end
    end

    // Per-packet sideband latches: digest from first beat, poison on any beat.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            digest_reg <= 1'b0;
            poison_reg <= 1'b0;
            cut_reg <= 1'b0;
            viol_reg <= 1'b0;
        end else if (user_beat) begin
            if (!in_pkt_reg) begin
                digest_reg <= user_sb[TXARB_SB_DIGEST];
                cut_reg <= user_sb[TXARB_SB_CUT];
                poison_reg <= user_sb[TXARB_SB_POISON];
            end else begin
                poison_reg <= poison_reg || user_sb[TXARB_SB_POISON];
            end
            if (user_sb[TXARB_SB_POISON] && user_sb[TXARB_SB_CUT]) begin
                viol_reg <= 1'b1;
            end
        end
    end

    // Output beat registers and own-packet counter.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid <= 1'b0;
            out_last <= 1'b0;
            out_own <= 1'b0;
            out_poison <= 1'b0;
            out_digest <= 1'b0;
            out_cut <= 1'b0;
            cnt_reg <= 16'h0;
        end else if (out_ready || !out_valid) begin
            out_valid <= user_beat || (state_reg == TXARB_SEND && !own_beat);
            out_own <= state_reg == TXARB_SEND && !own_beat;
            out_last <= user_beat ? user_last : (beat_reg == 8'(INT_LEN - 1));
            out_poison <= user_beat && (poison_reg || user_sb[TXARB_SB_POISON])
                          && in_pkt_reg | user_sb[TXARB_SB_POISON];
            out_digest <= user_beat && (in_pkt_reg ? digest_reg
                          : user_sb[TXARB_SB_DIGEST]);
            out_cut <= user_beat && (in_pkt_reg ? cut_reg : user_sb[TXARB_SB_CUT]);
            if (own_beat && beat_reg == 8'(INT_LEN - 1)) begin
                cnt_reg <= cnt_reg + 16'h1;
            end
        end
    end
endmodule : txarb_top
`default_nettype wire

// file: design/txarb_pkg.sv
// Package with constants and types shared by the transmit arbitration block.
package txarb_pkg;
    // ------------------------------------------------------------------
    // APB register map
    // ------------------------------------------------------------------
    localparam logic [7:0] TXARB_CTRL_OFS = 8'h00;
    localparam logic [7:0] TXARB_STAT_OFS = 8'h04;
    localparam logic [7:0] TXARB_CNT_OFS = 8'h08;
    // Control fields.
    localparam int TXARB_CTRL_GEN_BIT = 0;
    localparam int TXARB_CTRL_SPACE_BIT = 1;
    localparam logic [1:0] TXARB_CTRL_RST = 2'h2;
    // Status fields.
    localparam int TXARB_STAT_REQ_BIT = 0;
    localparam int TXARB_STAT_LATCH_BIT = 1;
    localparam int TXARB_STAT_PEND_BIT = 2;
    localparam int TXARB_STAT_INPKT_BIT = 3;
    localparam int TXARB_STAT_VIOL_BIT = 4;
    // ------------------------------------------------------------------
    // Sideband bit positions on the transmit user bus
    // ------------------------------------------------------------------
    localparam int TXARB_SB_DIGEST = 0;
    localparam int TXARB_SB_POISON = 1;
    localparam int TXARB_SB_CUT = 2;
    localparam int TXARB_SB_W = 4;
    // Length in beats of a self-generated packet.
    localparam int TXARB_INT_LEN = 3;
    // Arbiter states.
    typedef enum logic [1:0] {
        TXARB_IDLE,
        TXARB_REQ,
        TXARB_WAIT_BND,
        TXARB_SEND
    } txarb_state_t;
endpackage : txarb_pkg

// file: verif/txarb_top_sva.sv
// Checker of the arbitration and sideband relations at the block's ports.
`timescale 1ns/1ps
`default_nettype none
module txarb_top_sva (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // User stream.
    input wire logic user_valid,
    input wire logic user_ready,
    input wire logic user_last,
    input wire logic [txarb_pkg::TXARB_SB_W-1:0] user_sb,
    // Arbitration and output.
    input wire logic int_req,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic out_last,
    input wire logic out_own,
    input wire logic out_poison,
    input wire logic out_digest,
    input wire logic out_cut
);
    import txarb_pkg::*;
    logic uo_reg;
    logic oo_reg;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Tracks open user packets at the input and at the output.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uo_reg <= 1'b0;
            oo_reg <= 1'b0;
        end else begin
            if (user_valid && user_ready) uo_reg <= !user_last;
            if (out_valid && out_ready && !out_own) oo_reg <= !out_last;
        end
    end
    // A first beat of a user packet taken by the block.
    sequence s_first; user_valid && user_ready && !uo_reg; endsequence
    property p_own_req; out_valid && out_own |-> int_req; endproperty
    a_own_req: assert property (p_own_req) else $error("own beat without request");
    property p_req_drop; out_valid && out_ready && out_own && out_last |-> ##[1:3] !int_req; endproperty
    a_req_drop: assert property (p_req_drop) else $error("request kept after own packet");
    property p_req_gap; $fell(int_req) |=> !int_req; endproperty
    a_req_gap: assert property (p_req_gap) else $error("request raised again at once");
    property p_user_pass; user_valid && user_ready |=> out_valid && !out_own && out_last == $past(user_last); endproperty
    a_user_pass: assert property (p_user_pass) else $error("user beat not passed on");
    property p_own_bnd; oo_reg |-> !(out_valid && out_own); endproperty
    a_own_bnd: assert property (p_own_bnd) else $error("own beat inside user packet");
    property p_poison; user_valid && user_ready && user_sb[TXARB_SB_POISON] |=> out_poison; endproperty
    a_poison: assert property (p_poison) else $error("poison not marked");
    property p_digest; s_first |=> out_digest == $past(user_sb[TXARB_SB_DIGEST]); endproperty
    a_digest: assert property (p_digest) else $error("digest flag wrong");
    property p_cut; s_first |=> out_cut == $past(user_sb[TXARB_SB_CUT]); endproperty
    a_cut: assert property (p_cut) else $error("cut-through flag wrong");
endmodule : txarb_top_sva
bind txarb_top txarb_top_sva chk_u (.*);
`default_nettype wire

// file: verif/txarb_user_model.sv
// Model of the user transmit logic that feeds packets and answers requests.
`timescale 1ns/1ps
`default_nettype none
module txarb_user_model (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Commands; grant mode 0 never grants, 1 pulses once, 2 holds high.
    input wire logic go,
    input wire logic [3:0] len,
    input wire logic [txarb_pkg::TXARB_SB_W-1:0] sb,
    input wire logic [1:0] gnt_mode,
    // Stream and grant toward the block.
    output logic user_valid,
    output logic user_last,
    output logic [txarb_pkg::TXARB_SB_W-1:0] user_sb,
    input wire logic user_ready,
    output logic int_gnt,
    input wire logic int_req
);
    import txarb_pkg::*;
    logic [3:0] left_reg;
    logic seen_reg;
    // Sends beats back to back; idle lines carry a changing pattern.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            user_valid <= 1'b0;
            user_last <= 1'b0;
            user_sb <= '0;
            left_reg <= 4'h0;
        end else if (go && !user_valid) begin
            user_valid <= 1'b1;
            user_last <= (len == 4'h1);
            user_sb <= sb & ~{2'h0, sb[TXARB_SB_CUT], 1'b0};
            left_reg <= len;
        end else if (user_valid && user_ready) begin
            user_valid <= (left_reg != 4'h1);
            user_last <= (left_reg == 4'h2);
            left_reg <= left_reg - 4'h1;
        end else if (!user_valid) begin
            user_sb <= ~user_sb;
            user_last <= ~user_last;
        end
    end
    // Answers a new request once, or holds the grant, as the mode says.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_gnt <= 1'b0;
            seen_reg <= 1'b0;
        end else begin
            seen_reg <= int_req;
            int_gnt <= (gnt_mode == 2'h2) || (gnt_mode == 2'h1 && int_req && !seen_reg);
        end
    end
endmodule : txarb_user_model
`default_nettype wire

// file: verif/txarb_top_test.sv
// Self-checking bench for the transmit arbitration block.
`timescale 1ns/1ps
`default_nettype none
module txarb_top_test;
    import txarb_pkg::*;
    localparam int OWN_LEN = 2;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, err, user_valid, user_last, user_ready, int_req, int_gnt, out_ready = 1'b1;
    logic out_valid, out_last, out_own, out_poison, out_digest, out_cut;
    logic [3:0] len = 4'h1;
    logic [TXARB_SB_W-1:0] sb = '0, user_sb;
    logic [TXARB_SB_W-1:0] sbl [6] = '{4'h1, 4'h2, 4'h4, 4'h3, 4'h5, 4'h6};
    logic [1:0] gnt_mode = 2'h0;
    logic [2:0] flags;
    int error_cnt = 0, total_checks = 0, own_beats = 0, cyc = 0;
    txarb_top #(.INT_LEN(OWN_LEN)) dut_u (.*);
    txarb_user_model user_u (.*);
    // Clock of 5 ns.
    initial begin
        forever #2.5 pclk = ~pclk;
    end
    // Counts own beats, keeps the flags of the last user beat, bounds the run.
    always @(posedge pclk) begin
        cyc++;
        if (out_valid && out_ready && out_own) own_beats++;
        if (out_valid && out_ready && !out_own && out_last) flags = {out_cut, out_poison, out_digest};
        if (cyc == 20000) begin
            error_cnt++;
            final_report();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // One APB transfer; waits for pready, takes the answer at that edge, then idles one edge.
    // The idle edge keeps the next call from raising psel in the step that lowered it.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, q & m, e);
    endtask : rd
    // Waits for the request level; only the cycle ceiling ends a hang.
    task automatic wait_req(input logic v);
        while (int_req !== v) begin
            @(posedge pclk);
        end
    endtask : wait_req
    // Starts one user packet and waits until its last beat has gone out.
    task automatic send(input logic [3:0] l, input logic [3:0] s);
        len <= l;
        sb <= s;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        @(posedge pclk);
        while (user_valid !== 1'b0) begin
            @(posedge pclk);
        end
        repeat (3) @(posedge pclk);
    endtask : send
    task automatic final_report();
        if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    // Main sequence.
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd("ctrl", TXARB_CTRL_OFS, 32'h3, 32'h2);
        rd("stat", TXARB_STAT_OFS, 32'h1F, 32'h0);
        rd("hole", 8'h0C, 32'hFFFFFFFF, 32'h0);
        chk("hole_err", 32'(err), 32'h1);
        foreach (sbl[i]) begin
            send(4'(i + 1), sbl[i]);
            chk("sideband", 32'(flags), 32'({sbl[i][2], sbl[i][1] & !sbl[i][2], sbl[i][0]}));
        end
        apb(1'b1, TXARB_CTRL_OFS, 32'h3);
        wait_req(1'b1);
        chk("req_up", 32'(int_req), 32'h1);
        send(4'h4, 4'h0);
        repeat (20) @(posedge pclk);
        chk("held_req", 32'(int_req), 32'h1);
        chk("no_own", 32'(own_beats), 32'h0);
        gnt_mode <= 2'h2;
        wait_req(1'b0);
        chk("own_len", 32'(own_beats), 32'(OWN_LEN));
        rd("cnt", TXARB_CNT_OFS, 32'hFFFF, 32'h1);
        gnt_mode <= 2'h1;
        apb(1'b1, TXARB_CTRL_OFS, 32'h1);
        wait_req(1'b1);
        repeat (20) @(posedge pclk);
        rd("latched", TXARB_STAT_OFS, 32'h3, 32'h3);
        out_ready <= 1'b0;
        apb(1'b1, TXARB_CTRL_OFS, 32'h2);
        repeat (10) @(posedge pclk);
        chk("stall_req", 32'(int_req), 32'h1);
        out_ready <= 1'b1;
        wait_req(1'b0);
        chk("space_own", 32'(own_beats), 32'(2 * OWN_LEN));
        apb(1'b1, TXARB_CTRL_OFS, 32'h3);
        send(4'h8, 4'h1);
        wait_req(1'b0);
        chk("own_after", 32'(own_beats), 32'(3 * OWN_LEN));
        rd("viol", TXARB_STAT_OFS, 32'h10, 32'h0);
        final_report();
    end
endmodule : txarb_top_test
`default_nettype wire
